//--- logic/mmu_tlb.sv
// translation unit: buffer lookup, walker hand-off, faults, apb regs
// Function
// - disabled: map into first 16 mbyte region
// - enabled: buffer lookup comes first
// - hit and allowed: forward physical address
// - permission denied: permission fault to host
// - miss, walker off: translation fault
// - walker fills entry, then lookup repeats
// - walk finds nothing: fault to host
// - 32 entries, fully associative tag search
// - at most 31 locked, one free
// - full buffer: random unprotected victim
// - fill invalid unprotected entries first
// - tag, size, preserved, valid; valid matches
// - data: translation plus three permission levels
// - lookup tag is address bits 23:10
// - all fourteen tag bits always compared
// - physical tag 22 bits, unused zero
// - four block sizes: 1m, 64k, 4k, 1k
// - section compares all tag bits, not 13:10 only
// - size code 00 means section
// - codes 01, 10, 11: large, small, tiny
// - physical address: tag bits plus page index
// - global flush keeps preserved entries only
// - single flush clears valid and preserved
`timescale 1ns/100ps
module mmu_tlb (
	input wire logic pclk, // bus and core clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // unmapped address
	input wire logic req_valid, // memory request from port
	input wire logic [23:0] req_addr, // virtual address
	input wire logic req_write, // 1 write, 0 read
	output logic req_ready, // request taken
	output logic req_done, // request finished, pulse
	output logic req_fault, // finished with fault
	output logic tc_valid, // request to traffic ctrl
	output logic [31:0] tc_addr, // physical address
	output logic tc_write, // direction to traffic ctrl
	input wire logic tc_ready, // traffic ctrl accepts
	output logic walk_req, // walker fetch request
	output logic [23:0] walk_vaddr, // address to walk
	input wire logic walk_ack, // walker answer present
	input wire logic walk_found, // walker found translation
	input wire logic [21:0] walk_ptag, // walked physical tag
	input wire logic [1:0] walk_size, // walked size code
	input wire logic [1:0] walk_perm, // walked permission
	output logic host_fault // fault pending, level
);
	// ----------------------------------------------------------
	// types and state
	// ----------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LOOK = 5'h02,
		ST_WALK = 5'h04,
		ST_FWD = 5'h08,
		ST_DONE = 5'h10
	} state_t;

	typedef struct packed {
		state_t st; // request sequencer
		logic xl_en; // translation enabled
		logic walk_en; // walker enabled
		logic [4:0] base; // first unprotected entry
		logic [4:0] victim; // entry for host commands
		mmu_pkg::entry_t ld; // staged entry to write
		mmu_pkg::entry_t rd; // entry read back
		logic [2:0] flt; // sticky fault kinds
		logic [23:0] flt_va; // last faulting address
		logic [23:0] va; // held request address
		logic wr; // held request direction
		logic byp; // request bypassed lookup
		logic flt_req; // current request faulted
		logic [31:0] pa; // physical address out
		logic [4:0] lfsr; // random victim source
		logic [31:0] prdata; // latched read data
		mmu_pkg::entry_t [mmu_pkg::N_ENT-1:0] tlb; // buffer
	} regs_t;

	regs_t r_ff;
	regs_t nxt_r;

	// ----------------------------------------------------------
	// associative match
	// ----------------------------------------------------------
	logic [mmu_pkg::N_ENT-1:0] match; // per entry hit
	logic [13:0] look_tag; // tag from held address

	assign look_tag = r_ff.va[23:10];
	genvar gi;
	generate
		for (gi = 0; gi < mmu_pkg::N_ENT; gi++) begin : g_cmp
			// whole tag compared, size ignored here
			assign match[gi] = r_ff.tlb[gi].valid &&
				r_ff.tlb[gi].vtag == look_tag;
		end
	endgenerate

	// physical address from tag and page index by size
	function automatic logic [31:0] phys(input mmu_pkg::entry_t e,
		input logic [23:0] va);
		logic [31:0] p;
		p = 32'h0;
		unique case (e.size)
			mmu_pkg::SZ_SECT: p = {e.ptag[21:10], va[19:0]};
			mmu_pkg::SZ_LARGE: p = {e.ptag[21:6], va[15:0]};
			mmu_pkg::SZ_SMALL: p = {e.ptag[21:2], va[11:0]};
			mmu_pkg::SZ_TINY: p = {e.ptag, va[9:0]};
		endcase
		return p;
	endfunction

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	logic hit; // some valid entry matches
	logic [4:0] hit_idx; // matching entry
	logic perm_ok; // access type allowed
	logic inv_found; // free unprotected slot
	logic [4:0] inv_idx; // lowest free slot
	logic [4:0] vic_sel; // walker fill target
	logic setup; // apb setup cycle
	logic acc_wr; // apb write taking effect
	logic addr_ok; // mapped address
	logic [2:0] flt_set; // faults raised now
	logic [31:0] rmux; // read mux

	always_comb begin
		hit = |match;
		hit_idx = 5'h00;
		inv_found = 1'b0;
		inv_idx = 5'h00;
		// priority scan; hazard of duplicate tags ignored
		for (int i = mmu_pkg::N_ENT - 1; i >= 0; i--) begin
			if (match[i]) begin
				hit_idx = 5'(i);
			end
			if (5'(i) >= r_ff.base && !r_ff.tlb[i].valid) begin
				inv_found = 1'b1;
				inv_idx = 5'(i);
			end
		end
		// locked entries never chosen; base is below 32
		if (inv_found) begin
			vic_sel = inv_idx;
		end else if (r_ff.lfsr >= r_ff.base) begin
			vic_sel = r_ff.lfsr;
		end else begin
			vic_sel = r_ff.base;
		end
		// permission levels: none, read only, full
		unique case (r_ff.tlb[hit_idx].perm)
			mmu_pkg::AP_FULL: perm_ok = 1'b1;
			mmu_pkg::AP_RO: perm_ok = !r_ff.wr;
			default: perm_ok = 1'b0;
		endcase
	end

	always_comb begin
		nxt_r = r_ff;
		flt_set = 3'h0;
		setup = psel && !penable;
		acc_wr = psel && penable && pwrite;
		addr_ok = paddr == mmu_pkg::OFS_CTRL ||
			paddr == mmu_pkg::OFS_STAT || paddr == mmu_pkg::OFS_FVA ||
			paddr == mmu_pkg::OFS_LOCK || paddr == mmu_pkg::OFS_LDTAG ||
			paddr == mmu_pkg::OFS_LDDAT || paddr == mmu_pkg::OFS_CMD ||
			paddr == mmu_pkg::OFS_RDTAG || paddr == mmu_pkg::OFS_RDDAT;
		nxt_r.lfsr = {r_ff.lfsr[3:0], r_ff.lfsr[4] ^ r_ff.lfsr[2]};
		// request sequencer
		unique case (r_ff.st)
			ST_IDLE: begin
				if (req_valid) begin
					nxt_r.va = req_addr;
					nxt_r.wr = req_write;
					nxt_r.flt_req = 1'b0;
					nxt_r.byp = !r_ff.xl_en;
					if (!r_ff.xl_en) begin
						// straight into the first region
						nxt_r.pa = {mmu_pkg::REGION0_HI, req_addr};
						nxt_r.st = ST_FWD;
					end else begin
						nxt_r.st = ST_LOOK;
					end
				end
			end
			ST_LOOK: begin
				if (hit && perm_ok) begin
					nxt_r.pa = phys(r_ff.tlb[hit_idx], r_ff.va);
					nxt_r.st = ST_FWD;
				end else if (hit) begin
					flt_set[mmu_pkg::FLT_PERM] = 1'b1;
					nxt_r.st = ST_DONE;
				end else if (r_ff.walk_en) begin
					nxt_r.st = ST_WALK;
				end else begin
					flt_set[mmu_pkg::FLT_MISS] = 1'b1;
					nxt_r.st = ST_DONE;
				end
			end
			ST_WALK: begin
				if (walk_ack && walk_found) begin
					// install; full address tag so the retry hits
					nxt_r.tlb[vic_sel] = '{vtag: r_ff.va[23:10],
						size: walk_size, pres: 1'b0, valid: 1'b1,
						ptag: walk_ptag, perm: walk_perm};
					nxt_r.st = ST_LOOK;
				end else if (walk_ack) begin
					flt_set[mmu_pkg::FLT_WALK] = 1'b1;
					nxt_r.st = ST_DONE;
				end
			end
			ST_FWD: begin
				if (tc_ready) begin
					nxt_r.st = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_r.st = ST_IDLE;
			end
		endcase
		if (|flt_set) begin
			nxt_r.flt_req = 1'b1;
			nxt_r.flt_va = r_ff.va;
		end
		// register writes take effect in the access phase
		if (acc_wr) begin
			unique case (paddr)
				mmu_pkg::OFS_CTRL: begin
					nxt_r.xl_en = pwdata[mmu_pkg::CTRL_XL];
					nxt_r.walk_en = pwdata[mmu_pkg::CTRL_WALK];
				end
				mmu_pkg::OFS_STAT: begin
					nxt_r.flt = r_ff.flt & ~pwdata[2:0];
				end
				mmu_pkg::OFS_LOCK: begin
					// lock pointers only move with the walker off
					if (!r_ff.walk_en) begin
						nxt_r.base = pwdata[4:0];
						nxt_r.victim = pwdata[mmu_pkg::LOCK_VIC +: 5];
					end
				end
				mmu_pkg::OFS_LDTAG: begin
					nxt_r.ld.vtag = pwdata[13:0];
					nxt_r.ld.size = pwdata[15:14];
					nxt_r.ld.pres = pwdata[16];
					nxt_r.ld.valid = pwdata[17];
				end
				mmu_pkg::OFS_LDDAT: begin
					nxt_r.ld.ptag = pwdata[21:0];
					nxt_r.ld.perm = pwdata[23:22];
				end
				mmu_pkg::OFS_CMD: begin
					if (pwdata[mmu_pkg::CMD_GF]) begin
						for (int i = 0; i < mmu_pkg::N_ENT; i++) begin
							nxt_r.tlb[i].valid = r_ff.tlb[i].valid &&
								r_ff.tlb[i].pres;
						end
					end
					if (pwdata[mmu_pkg::CMD_FL]) begin
						nxt_r.tlb[r_ff.victim].valid = 1'b0;
						nxt_r.tlb[r_ff.victim].pres = 1'b0;
					end
					if (pwdata[mmu_pkg::CMD_WR]) begin
						nxt_r.tlb[r_ff.victim] = r_ff.ld;
					end
					if (pwdata[mmu_pkg::CMD_RD]) begin
						nxt_r.rd = r_ff.tlb[r_ff.victim];
					end
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over software clear
		nxt_r.flt = nxt_r.flt | flt_set;
		// read data latched in setup, presented in access
		unique case (paddr)
			mmu_pkg::OFS_CTRL: rmux = {30'h0, r_ff.walk_en, r_ff.xl_en};
			mmu_pkg::OFS_STAT: rmux = {29'h0, r_ff.flt};
			mmu_pkg::OFS_FVA: rmux = {8'h00, r_ff.flt_va};
			mmu_pkg::OFS_LOCK: rmux = {19'h0, r_ff.victim, 3'h0, r_ff.base};
			mmu_pkg::OFS_LDTAG: rmux = {14'h0, r_ff.ld.valid, r_ff.ld.pres,
				r_ff.ld.size, r_ff.ld.vtag};
			mmu_pkg::OFS_LDDAT: rmux = {8'h00, r_ff.ld.perm, r_ff.ld.ptag};
			mmu_pkg::OFS_RDTAG: rmux = {14'h0, r_ff.rd.valid, r_ff.rd.pres,
				r_ff.rd.size, r_ff.rd.vtag};
			mmu_pkg::OFS_RDDAT: rmux = {8'h00, r_ff.rd.perm, r_ff.rd.ptag};
			default: rmux = 32'h0;
		endcase
		if (setup) begin
			nxt_r.prdata = rmux;
		end
	end

	// ----------------------------------------------------------
	// state register
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
			r_ff.st <= ST_IDLE;
			r_ff.lfsr <= mmu_pkg::LFSR_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	assign prdata = r_ff.prdata;
	assign pready = psel && penable; // zero wait states
	assign pslverr = psel && penable && !addr_ok;
	assign req_ready = r_ff.st == ST_IDLE;
	assign req_done = r_ff.st == ST_DONE;
	assign req_fault = r_ff.flt_req;
	assign tc_valid = r_ff.st == ST_FWD;
	assign tc_addr = r_ff.pa;
	assign tc_write = r_ff.wr;
	assign walk_req = r_ff.st == ST_WALK;
	assign walk_vaddr = r_ff.va;
	assign host_fault = |r_ff.flt;

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_walk_ok;
		walk_req && walk_ack && walk_found;
	endsequence

	a_bypass_map: assert property (
		tc_valid && r_ff.byp |-> tc_addr == {8'h00, r_ff.va})
		else $error("bypass address not in first region");
	a_lookup_first: assert property (
		$rose(walk_req) |-> $past(r_ff.st) == ST_LOOK)
		else $error("walk started without lookup");
	a_hit_forward: assert property (
		r_ff.st == ST_LOOK && hit && perm_ok |=> tc_valid && !req_fault)
		else $error("permitted hit not forwarded");
	// flag and done pulse land together, one cycle after lookup
	a_perm_fault: assert property (
		r_ff.st == ST_LOOK && hit && !perm_ok |=>
		r_ff.flt[mmu_pkg::FLT_PERM] && !tc_valid && req_done && req_fault)
		else $error("permission fault missing");
	a_miss_fault: assert property (
		r_ff.st == ST_LOOK && !hit && !r_ff.walk_en |=>
		r_ff.flt[1] && host_fault && !tc_valid)
		else $error("translation fault missing");
	a_walk_install: assert property (
		s_walk_ok |=> r_ff.st == ST_LOOK && hit)
		else $error("walked entry not installed");
	a_walk_fault: assert property (
		walk_req && walk_ack && !walk_found |=>
		r_ff.flt[mmu_pkg::FLT_WALK] && req_done && req_fault)
		else $error("walk fault missing");
	a_victim_free: assert property (
		vic_sel >= r_ff.base)
		else $error("walker victim is locked");
	a_fill_first: assert property (
		inv_found |-> !r_ff.tlb[vic_sel].valid)
		else $error("valid entry replaced before free one");
	a_no_fwd_fault: assert property (
		req_done && req_fault |-> $past(r_ff.st, 2) != ST_FWD &&
		$past(r_ff.st) != ST_FWD)
		else $error("faulted request forwarded");
endmodule

//--- logic/mmu_pkg.sv
// shared constants and types for the dsp address translation unit
package mmu_pkg;
	// ----------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000; // enables
	localparam logic [11:0] OFS_STAT = 12'h004; // fault flags, w1c
	localparam logic [11:0] OFS_FVA = 12'h008; // faulting address
	localparam logic [11:0] OFS_LOCK = 12'h00c; // base and victim
	localparam logic [11:0] OFS_LDTAG = 12'h010; // entry tag to load
	localparam logic [11:0] OFS_LDDAT = 12'h014; // entry data to load
	localparam logic [11:0] OFS_CMD = 12'h018; // command strobes
	localparam logic [11:0] OFS_RDTAG = 12'h01c; // tag read back
	localparam logic [11:0] OFS_RDDAT = 12'h020; // data read back
	// ----------------------------------------------------------
	// field positions
	// ----------------------------------------------------------
	localparam int CTRL_XL = 0; // translation enable
	localparam int CTRL_WALK = 1; // table walk enable
	localparam int FLT_PERM = 0; // permission fault
	localparam int FLT_MISS = 1; // miss with walker off
	localparam int FLT_WALK = 2; // walk found nothing
	localparam int LOCK_VIC = 8; // victim field lsb
	localparam int CMD_WR = 0; // write entry
	localparam int CMD_RD = 1; // read entry
	localparam int CMD_FL = 2; // flush one entry
	localparam int CMD_GF = 3; // global flush
	// ----------------------------------------------------------
	// sizes, codes and reset values
	// ----------------------------------------------------------
	localparam int N_ENT = 32; // buffer entries
	localparam logic [1:0] SZ_SECT = 2'h0; // 1 mbyte section
	localparam logic [1:0] SZ_LARGE = 2'h1; // 64 kbyte page
	localparam logic [1:0] SZ_SMALL = 2'h2; // 4 kbyte page
	localparam logic [1:0] SZ_TINY = 2'h3; // 1 kbyte page
	localparam logic [1:0] AP_NONE = 2'h0; // no access
	localparam logic [1:0] AP_RO = 2'h1; // read only
	localparam logic [1:0] AP_FULL = 2'h2; // full access
	localparam logic [7:0] REGION0_HI = 8'h00; // first 16 mbytes
	localparam logic [4:0] LFSR_RST = 5'h01; // nonzero seed
	// one buffer entry: tag part then data part
	typedef struct packed {
		logic [13:0] vtag; // virtual tag
		logic [1:0] size; // block size code
		logic pres; // survives global flush
		logic valid; // takes part in matching
		logic [21:0] ptag; // physical tag
		logic [1:0] perm; // access permission
	} entry_t;
endpackage

//--- test/mmu_far_model.sv
// far side model: traffic controller and table walker memory
`timescale 1ns/100ps
module mmu_far_model (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic [3:0] dly, // cycles before answering
	input wire logic tc_valid, // request from the unit
	output logic tc_ready, // controller accepts
	input wire logic walk_req, // fetch request
	output logic walk_ack, // fetch answer
	output logic walk_found, // table held a translation
	output logic [21:0] walk_ptag, // fetched physical tag
	output logic [1:0] walk_size, // fetched size code
	output logic [1:0] walk_perm, // fetched permission
	input wire logic cfg_found, // what the tables hold
	input wire logic [21:0] cfg_ptag, // tag to hand back
	input wire logic [1:0] cfg_size, // size to hand back
	input wire logic [1:0] cfg_perm // permission to hand back
);
	logic [3:0] tcnt_ff; // cycles the transfer has waited
	logic [3:0] wcnt_ff; // cycles the fetch has waited
	// ------------------------------------------------------
	// wait counters
	// ------------------------------------------------------
	// counting keeps a slow answer honest: request held throughout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcnt_ff <= 4'h0;
			wcnt_ff <= 4'h0;
		end else begin
			tcnt_ff <= (tc_valid && !tc_ready) ? tcnt_ff + 4'h1 : 4'h0;
			wcnt_ff <= (walk_req && !walk_ack) ? wcnt_ff + 4'h1 : 4'h0;
		end
	end
	assign tc_ready = tc_valid && (tcnt_ff >= dly);
	assign walk_ack = walk_req && (wcnt_ff >= dly);
	// outside an answer the lines carry the inverse, never a stale copy
	assign walk_found = walk_ack ? cfg_found : !cfg_found;
	assign walk_ptag = walk_ack ? cfg_ptag : ~cfg_ptag;
	assign walk_size = walk_ack ? cfg_size : ~cfg_size;
	assign walk_perm = walk_ack ? cfg_perm : ~cfg_perm;
endmodule

//--- test/dsp_mmu_tlb_translation_tb.sv
// testbench for the address translation unit
`timescale 1ns/100ps
module dsp_mmu_tlb_translation_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // bus
	logic [11:0] paddr; // bus address
	logic [31:0] pwdata, prdata, tc_addr; // bus data, physical address
	logic req_valid, req_write, req_ready, req_done, req_fault; // port
	logic [23:0] req_addr, walk_vaddr; // virtual addresses
	logic tc_valid, tc_write, tc_ready, walk_req, walk_ack; // far side
	logic walk_found, host_fault, cfg_found; // flags
	logic [21:0] walk_ptag, cfg_ptag; // physical tags
	logic [1:0] walk_size, walk_perm, cfg_size, cfg_perm; // codes
	logic [3:0] dly; // far side delay
	int err_count, tests_run; // tallies
	localparam logic [31:0] NOFWD = 32'hffffffff; // nothing forwarded
	localparam logic [23:0] VA_T [4] = '{24'h300155, 24'h5a0123,
		24'h7c4321, 24'h9abcde}; // one address per size
	localparam logic [21:0] PT_T [4] = '{22'h048c00, 22'h2fbbc0,
		22'h226af0, 22'h2aaaaa}; // unused tag bits kept zero
	mmu_tlb dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .req_valid, .req_addr,
		.req_write, .req_ready, .req_done, .req_fault, .tc_valid, .tc_addr,
		.tc_write, .tc_ready, .walk_req, .walk_vaddr, .walk_ack, .walk_found,
		.walk_ptag, .walk_size, .walk_perm, .host_fault);
	mmu_far_model far_u (.pclk, .presetn, .dly, .tc_valid, .tc_ready,
		.walk_req, .walk_ack, .walk_found, .walk_ptag, .walk_size,
		.walk_perm, .cfg_found, .cfg_ptag, .cfg_size, .cfg_perm);
	// ------------------------------------------------------
	// clock, compare and closing
	// ------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------------
	// bus and request drivers
	// ------------------------------------------------------
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; only the watchdog ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	// one memory request; pa stays all ones if never forwarded
	task automatic go(input logic [23:0] va, input logic w,
		input logic ef, input logic [31:0] ep);
		logic [31:0] pa;
		pa = NOFWD;
		@(posedge pclk);
		req_valid <= 1'b1;
		req_addr <= va;
		req_write <= w;
		do @(posedge pclk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req_addr <= ~va; // released lines carry no stale copy
		do begin
			@(posedge pclk);
			if (walk_req === 1'b1 && walk_ack === 1'b1) begin
				chk("walk_vaddr", {8'h00, va}, {8'h00, walk_vaddr});
			end
			if (tc_valid === 1'b1 && tc_ready === 1'b1) begin
				pa = tc_addr;
				chk("tc_write", {31'h0, w}, {31'h0, tc_write});
			end
		end while (req_done !== 1'b1);
		chk("req_fault", {31'h0, ef}, {31'h0, req_fault});
		chk("tc_addr", ep, pa);
	endtask
	// load one entry at slot i; walker must be off for the lock write
	task automatic put(input logic [4:0] i, input logic [1:0] sz,
		input logic pr, input logic [23:0] va, input logic [21:0] pt,
		input logic [1:0] ap);
		wr(mmu_pkg::OFS_LOCK, {19'h0, i, 8'h00});
		wr(mmu_pkg::OFS_LDTAG, {14'h0, 1'b1, pr, sz, va[23:10]});
		wr(mmu_pkg::OFS_LDDAT, {8'h0, ap, pt});
		wr(mmu_pkg::OFS_CMD, 32'h1 << mmu_pkg::CMD_WR);
	endtask
	task automatic rdtag(input logic [4:0] i, output logic [31:0] q);
		wr(mmu_pkg::OFS_LOCK, {19'h0, i, 8'h00});
		wr(mmu_pkg::OFS_CMD, 32'h1 << mmu_pkg::CMD_RD);
		rd(mmu_pkg::OFS_RDTAG, q);
	endtask
	// fault flags read, checked against the host line, then cleared
	task automatic stat(input int b);
		logic [31:0] q;
		rd(mmu_pkg::OFS_STAT, q);
		chk("status", 32'h1 << b, q);
		chk("host_fault", 32'h1, {31'h0, host_fault});
		wr(mmu_pkg::OFS_STAT, 32'h7);
	endtask
	function automatic logic [31:0] pa_of(input logic [1:0] sz,
		input logic [21:0] pt, input logic [23:0] va);
		case (sz)
			mmu_pkg::SZ_SECT: pa_of = {pt[21:10], va[19:0]};
			mmu_pkg::SZ_LARGE: pa_of = {pt[21:6], va[15:0]};
			mmu_pkg::SZ_SMALL: pa_of = {pt[21:2], va[11:0]};
			default: pa_of = {pt, va[9:0]};
		endcase
	endfunction
	// ------------------------------------------------------
	// scenarios
	// ------------------------------------------------------
	task automatic t_bypass();
		logic [31:0] q;
		logic e;
		rd(mmu_pkg::OFS_CTRL, q);
		chk("ctrl reset", 32'h0, q);
		go(24'hfedcba, 1'b1, 1'b0, 32'h00fedcba);
		apb(1'b0, 12'h0fc, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
	endtask
	// every size code, then a tag with a stray low bit that must miss
	task automatic t_sizes();
		for (int i = 0; i < 4; i++)
			put(5'(i), 2'(i), 1'b0, VA_T[i], PT_T[i], mmu_pkg::AP_FULL);
		wr(mmu_pkg::OFS_CTRL, 32'h1);
		for (int i = 0; i < 4; i++)
			go(VA_T[i], i[0], 1'b0, pa_of(2'(i), PT_T[i], VA_T[i]));
		go(VA_T[0] | 24'h000400, 1'b0, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_MISS);
	endtask
	task automatic t_perm();
		wr(mmu_pkg::OFS_CTRL, 32'h0);
		put(5'd4, mmu_pkg::SZ_SMALL, 1'b0, 24'h111000, 22'h0, mmu_pkg::AP_RO);
		put(5'd5, mmu_pkg::SZ_SMALL, 1'b0, 24'h112000, 22'h4, 2'h0);
		wr(mmu_pkg::OFS_CTRL, 32'h1);
		go(24'h111004, 1'b0, 1'b0, 32'h00000004);
		go(24'h111004, 1'b1, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_PERM);
		go(24'h112008, 1'b0, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_PERM);
	endtask
	task automatic t_walk();
		logic [31:0] q;
		dly <= 4'h3;
		cfg_found <= 1'b1;
		cfg_ptag <= 22'h1234c0;
		cfg_size <= mmu_pkg::SZ_SMALL;
		cfg_perm <= mmu_pkg::AP_FULL;
		wr(mmu_pkg::OFS_CTRL, 32'h3);
		go(24'h444010, 1'b0, 1'b0, 32'h48d30010);
		wr(mmu_pkg::OFS_CTRL, 32'h1);
		rdtag(5'd6, q);
		// valid, not preserved, small page, full address tag
		chk("walked tag", 32'h29110, q & 32'h3ffff);
		wr(mmu_pkg::OFS_CTRL, 32'h3);
		cfg_found <= 1'b0;
		go(VA_T[3], 1'b0, 1'b0, pa_of(2'h3, PT_T[3], VA_T[3]));
		go(24'h555000, 1'b0, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_WALK);
		cfg_found <= 1'b1;
		cfg_perm <= mmu_pkg::AP_RO;
		go(24'h666000, 1'b1, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_PERM);
	endtask
	task automatic t_flush();
		logic [31:0] q;
		wr(mmu_pkg::OFS_CTRL, 32'h1);
		put(5'd0, mmu_pkg::SZ_SECT, 1'b1, VA_T[0], PT_T[0], mmu_pkg::AP_FULL);
		wr(mmu_pkg::OFS_CMD, 32'h1 << mmu_pkg::CMD_GF);
		go(VA_T[0], 1'b0, 1'b0, pa_of(2'h0, PT_T[0], VA_T[0]));
		go(VA_T[1], 1'b0, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_MISS);
		wr(mmu_pkg::OFS_CMD, 32'h1 << mmu_pkg::CMD_FL); // victim still 0
		go(VA_T[0], 1'b0, 1'b1, NOFWD);
		stat(mmu_pkg::FLT_MISS);
		rdtag(5'd0, q);
		chk("flushed flags", 32'h0, q & 32'h30000);
	endtask
	// ------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------
	initial begin
		{psel, penable, pwrite, req_valid, req_write, cfg_found} = 6'h0;
		{paddr, pwdata, req_addr, cfg_ptag} = 90'h0;
		{cfg_size, cfg_perm, dly} = 8'h0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_bypass();
		t_sizes();
		t_perm();
		t_walk();
		t_flush();
		results();
	end
	// the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		results();
	end
endmodule
